// ==== rtl/mfc_counter.sv ====
// Multiplying frequency counter with multiplexed readout
// Overview of operation
// - Low two ranges multiply, high two count direct
// - Reference divided by 100 or 10, gated
// - Gated count held, then presets divider chain
// - Divider chain clocked by undivided reference
// - Multiplied pulses counted over 100 ms gate
// - Third range counts input over 0.1 s
// - Top range prescales input by ten first
// - Digits strobed one at a time
// - Decimal point set only by range
// - Cycle pulse 10 us, 1 us top range
// - Retriggerable timeout blanks readout when input stops
`timescale 1ns/1ps
`default_nettype none
`include "mfc_defs.svh"
module mfc_counter #(
    parameter int REF_HZ    = `MFC_REF_HZ_DEF,
    parameter int BLANK_CYC = `MFC_BLANK_CYC_DEF,
    parameter int GATE_CYC  = `MFC_GATE_MS * (`MFC_CLK_HZ / 1000),
    parameter int MUX_CYC   = `MFC_MUX_CYC
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_ref_tick,
    input  wire logic             i_cycle_edge,
    input  wire logic [1:0]       i_range,
    output logic                  o_cycle_pulse,
    output mfc_pkg::mfc_disp_t    o_disp
);
    localparam int W = `MFC_CNT_W;

    // Binary to one BCD digit, picked by index
    function automatic logic [3:0] bcd_digit(input logic [W-1:0] v,
                                             input logic [2:0] idx);
        logic [W-1:0] t;
        t = v;
        for (int k = 0; k < 6; k++)
        begin
            if (k < int'(idx))
                t = t / W'(10);
        end
        return 4'(t % W'(10));
    endfunction

    mfc_pkg::mfc_range_t rng;
    logic mult_mode;
    assign rng = mfc_pkg::mfc_range_t'(i_range);
    assign mult_mode = (rng == mfc_pkg::MFC_R_LOW) ||
                       (rng == mfc_pkg::MFC_R_MID);

    // Cycle monostable state
    logic [15:0] pw_q, pw_d;
    // Blanking timeout
    logic [31:0] idle_q, idle_d;
    // Reference divider and period gate
    logic [6:0]  rdiv_q, rdiv_d;
    logic        per_gate_q, per_gate_d;
    logic [W-1:0] per_cnt_q, per_cnt_d;
    logic [W-1:0] hold_q, hold_d;
    // Presettable divider chain
    logic [W-1:0] pre_q, pre_d;
    // Prescaler and gate counter
    logic [3:0]  psc_q, psc_d;
    logic [31:0] gate_q, gate_d;
    logic [W-1:0] cnt_q, cnt_d;
    logic [W-1:0] disp_q, disp_d;
    // Digit strobe
    logic [31:0] mux_q, mux_d;
    logic [2:0]  dig_q, dig_d;
    mfc_pkg::mfc_disp_t out_q, out_d;

    logic        pulse_start;
    logic [15:0] pw_len;
    logic [6:0]  div_n;
    logic        div_tick;
    logic        mul_tick;
    logic        cnt_tick;
    logic        gate_end;
    logic        mux_wrap;

    // Monostable and blanking timeout
    always_comb
    begin
        pw_len = (rng == mfc_pkg::MFC_R_TOP) ? 16'(`MFC_PW_SHORT_CYC)
                                             : 16'(`MFC_PW_LONG_CYC);
        // Edges inside a running pulse are ignored, as in a monostable
        pulse_start = i_cycle_edge && (pw_q == 16'h0000);
        pw_d = pulse_start ? pw_len
             : (pw_q != 16'h0000) ? pw_q - 16'h0001 : pw_q;
        idle_d = pulse_start ? 32'h0000_0000
               : (idle_q != 32'(BLANK_CYC)) ? idle_q + 32'h0000_0001
               : idle_q;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            pw_q   <= 16'h0000;
            // Readout stays dark until the first input cycle is seen
            idle_q <= 32'(BLANK_CYC);
        end
        else
        begin
            pw_q   <= pw_d;
            idle_q <= idle_d;
        end
    end

    // Period gate and multiplier chain
    always_comb
    begin
        div_n = (rng == mfc_pkg::MFC_R_LOW) ? 7'(`MFC_DIV_LOW)
                                            : 7'(`MFC_DIV_MID);
        // A range change may leave the divider above its new end value
        div_tick = i_ref_tick && (rdiv_q >= div_n - 7'h01);
        rdiv_d = !i_ref_tick ? rdiv_q
               : div_tick ? 7'h00 : rdiv_q + 7'h01;
        per_gate_d = pulse_start ? !per_gate_q : per_gate_q;
        per_cnt_d = per_cnt_q;
        hold_d = hold_q;
        if (pulse_start && per_gate_q)
        begin
            // Gate spans one full input period, closing edge included,
            // so a steady input whose period is a whole number of divider ticks always yields the same held count
            hold_d = per_cnt_q + W'(div_tick);
            per_cnt_d = '0;
        end
        else if (pulse_start)
            per_cnt_d = '0;
        else if (per_gate_q && div_tick)
            per_cnt_d = per_cnt_q + W'(1);
        // Chain reloads itself; an empty holder keeps it parked at zero
        // rather than letting it wrap and stall for a full count
        mul_tick = i_ref_tick && (pre_q <= W'(1)) && (hold_q != '0);
        pre_d = !i_ref_tick ? pre_q
              : (pre_q <= W'(1)) ? hold_q : pre_q - W'(1);
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            rdiv_q     <= 7'h00;
            per_gate_q <= 1'b0;
            per_cnt_q  <= '0;
            hold_q     <= '0;
            pre_q      <= '0;
        end
        else
        begin
            rdiv_q     <= rdiv_d;
            per_gate_q <= per_gate_d;
            per_cnt_q  <= per_cnt_d;
            hold_q     <= hold_d;
            pre_q      <= pre_d;
        end
    end

    // Prescaler, gate timer and gated counter
    always_comb
    begin
        psc_d = psc_q;
        if (pulse_start)
            psc_d = (psc_q == 4'(`MFC_PRESCALE - 1)) ? 4'h0
                                                     : psc_q + 4'h1;
        cnt_tick = mult_mode ? mul_tick
                 : (rng == mfc_pkg::MFC_R_TOP)
                   ? (pulse_start && psc_q == 4'(`MFC_PRESCALE - 1))
                   : pulse_start;
        gate_end = (gate_q == 32'(GATE_CYC - 1));
        gate_d = gate_end ? 32'h0000_0000 : gate_q + 32'h0000_0001;
        cnt_d = gate_end ? '0 : cnt_q + W'(cnt_tick);
        // The tick of the last gate cycle still counts towards the result
        disp_d = gate_end ? cnt_q + W'(cnt_tick) : disp_q;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            psc_q  <= 4'h0;
            gate_q <= 32'h0000_0000;
            cnt_q  <= '0;
            disp_q <= '0;
        end
        else
        begin
            psc_q  <= psc_d;
            gate_q <= gate_d;
            cnt_q  <= cnt_d;
            disp_q <= disp_d;
        end
    end

    // Digit strobe and readout register
    always_comb
    begin
        mux_wrap = (mux_q == 32'(MUX_CYC - 1));
        mux_d = mux_wrap ? 32'h0000_0000 : mux_q + 32'h0000_0001;
        dig_d = dig_q;
        if (mux_wrap)
            dig_d = (dig_q == 3'(`MFC_NDIG - 1)) ? 3'h0
                                                 : dig_q + 3'h1;
        out_d.digit_en = 6'h01 << dig_q;
        out_d.bcd      = bcd_digit(disp_q, dig_q);
        // Count is in tenths of Hz on lowest range, ten times coarser per range up to hundreds of Hz on top range
        out_d.dp       = (dig_q == 3'(i_range) + 3'h1);
        out_d.blank    = (idle_q == 32'(BLANK_CYC));
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            mux_q <= 32'h0000_0000;
            dig_q <= 3'h0;
            out_q <= '{digit_en: 6'h00, bcd: 4'h0, dp: 1'b0, blank: 1'b1};
        end
        else
        begin
            mux_q <= mux_d;
            dig_q <= dig_d;
            out_q <= out_d;
        end
    end

    assign o_cycle_pulse = (pw_q != 16'h0000);
    assign o_disp = out_q;
endmodule
`default_nettype wire

// ==== shared/mfc_defs.svh ====
// Constants of the multiplying frequency counter
`ifndef MFC_DEFS_SVH
`define MFC_DEFS_SVH

`define MFC_CLK_HZ          100000000
`define MFC_REF_HZ_DEF      1000000
`define MFC_GATE_MS         100
`define MFC_GATE_CYC(f)     ((f) / 1000 * `MFC_GATE_MS)
`define MFC_DIV_LOW         100
`define MFC_DIV_MID         10
`define MFC_PRESCALE        10
`define MFC_PW_LONG_NS      10000
`define MFC_PW_SHORT_NS     1000
`define MFC_PW_LONG_CYC     (`MFC_PW_LONG_NS / 10)
`define MFC_PW_SHORT_CYC    (`MFC_PW_SHORT_NS / 10)
`define MFC_BLANK_CYC_DEF   50000000
`define MFC_MUX_CYC         100000
`define MFC_NDIG            6
`define MFC_CNT_W           24

`endif

// ==== shared/mfc_pkg.sv ====
// Types of the multiplying frequency counter
`default_nettype none
package mfc_pkg;
    typedef enum logic [1:0] {
        MFC_R_LOW  = 2'b00,
        MFC_R_MID  = 2'b01,
        MFC_R_HIGH = 2'b10,
        MFC_R_TOP  = 2'b11
    } mfc_range_t;

    typedef struct packed {
        logic [5:0] digit_en;
        logic [3:0] bcd;
        logic       dp;
        logic       blank;
    } mfc_disp_t;
endpackage
`default_nettype wire

// ==== verification/mfc_pulse_src.sv ====
// Comparator edge source and crystal tick model
`timescale 1ns/1ps
`default_nettype none
module mfc_pulse_src (
    input  wire logic        i_clk,
    input  wire logic        i_run,
    input  wire logic [15:0] i_period,
    output logic             o_edge,
    output logic             o_tick
);
    logic [15:0] cnt_q = 16'h0000;
    logic        tick_q = 1'b0;
    always_ff @(posedge i_clk)
    begin
        tick_q <= ~tick_q;
        cnt_q  <= (cnt_q >= i_period - 16'h0001) ? 16'h0000
                                                 : cnt_q + 16'h0001;
    end
    // A stopped oscillator gives no edges at all
    assign o_edge = i_run && cnt_q == 16'h0000;
    assign o_tick = tick_q;
endmodule
`default_nettype wire

// ==== verification/mfc_chk_assertions.sv ====
// Port checker for the frequency counter
`timescale 1ns/1ps
`default_nettype none
module mfc_chk #(
    parameter int BLANK_CYC = 2000
) (
    input wire logic               i_clk,
    input wire logic               i_rst,
    input wire logic               i_cycle_edge,
    input wire logic [1:0]         i_range,
    input wire logic               o_cycle_pulse,
    input wire mfc_pkg::mfc_disp_t o_disp
);
    int hi_q, hi_d, idle_q, idle_d;
    always_comb
    begin
        hi_d   = o_cycle_pulse ? hi_q + 1 : 0;
        idle_d = o_cycle_pulse ? 0 : idle_q + 1;
    end
    always_ff @(posedge i_clk)
    begin
        hi_q   <= i_rst ? 0 : hi_d;
        idle_q <= i_rst ? 0 : idle_d;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    pulse_width_a: assert property ($fell(o_cycle_pulse) |->
        hi_q == (i_range == 2'h3 ? 10'h064 : 10'h3E8)) else $error("width");
    pulse_start_a: assert property (i_cycle_edge &&
        !o_cycle_pulse |=> o_cycle_pulse) else $error("no pulse");
    pulse_cause_a: assert property ($rose(o_cycle_pulse) |->
        $past(i_cycle_edge)) else $error("stray pulse");
    one_digit_a: assert property ($onehot0(o_disp.digit_en))
        else $error("digits");
    digit_step_a: assert property ($changed(o_disp.digit_en) &&
        $past(o_disp.digit_en) != 0 && o_disp.digit_en != 0
        |=> $stable(o_disp.digit_en)[*3]) else $error("strobe");
    dp_range_a: assert property (o_disp.dp && !o_disp.blank &&
        $stable(i_range) |-> o_disp.digit_en[{1'b0, i_range} + 3'h1])
        else $error("point");
    blank_idle_a: assert property (idle_q > BLANK_CYC + 4
        |-> o_disp.blank) else $error("not blanked");
    reset_dark_a: assert property ($fell(i_rst) |-> o_disp.blank &&
        o_disp.digit_en == 6'h00) else $error("reset state");
endmodule
bind mfc_counter mfc_chk #(.BLANK_CYC(BLANK_CYC)) chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_cycle_edge(i_cycle_edge),
    .i_range(i_range), .o_cycle_pulse(o_cycle_pulse), .o_disp(o_disp));
`default_nettype wire

// ==== verification/mfc_counter_tb_top.sv ====
// Self-checking bench for the frequency counter
`timescale 1ns/1ps
`default_nettype none
`include "mfc_defs.svh"
module mfc_counter_tb_top;
    logic               clk = 1'b0, rst = 1'b1, run = 1'b0;
    logic [1:0]         rng = 2'h2;
    logic [15:0]        per = 16'h04E2;
    logic               edg, tick, pulse;
    mfc_pkg::mfc_disp_t disp;
    int                 err_total = 0, checked = 0, cyc = 0;
    initial forever #5 clk = ~clk;
    mfc_pulse_src src (.i_clk(clk), .i_run(run), .i_period(per),
        .o_edge(edg), .o_tick(tick));
    mfc_counter #(.BLANK_CYC(2000), .GATE_CYC(5000), .MUX_CYC(4)) uut (
        .i_clk(clk), .i_rst(rst), .i_ref_tick(tick), .i_cycle_edge(edg),
        .i_range(rng), .o_cycle_pulse(pulse), .o_disp(disp));
    task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s exp %0d seen %0d", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 95000)
        begin
            err_total++;
            finish_test();
        end
    end
    // Digits are strobed least significant first and read back most significant first; dp must sit on range+1
    task automatic measure(logic [1:0] r, logic [15:0] p, int exp);
        logic [23:0] v;
        int          n, w;
        v = 24'h00_0000;
        @(posedge clk);
        run <= 1'b0;
        repeat (1100) @(posedge clk);
        rng <= r;
        per <= p;
        run <= 1'b1;
        repeat (16000) @(posedge clk);
        for (int k = 5; k >= 0; k--)
        begin
            n = 0;
            @(negedge clk);
            while (disp.digit_en !== (6'h01 << k) && n < 64)
            begin
                @(negedge clk);
                n++;
            end
            v = v * 24'h00_000A + {20'h0_0000, disp.bcd};
            check("dp", {23'h0, disp.dp}, (k == r + 1) ? 1 : 0);
        end
        // Skip a pulse already under way, then time a whole one
        while (pulse === 1'b1)
            @(negedge clk);
        while (pulse !== 1'b1)
            @(negedge clk);
        n = 0;
        while (pulse === 1'b1)
        begin
            @(negedge clk);
            n++;
        end
        w = (r == 2'h3) ? `MFC_PW_SHORT_CYC : `MFC_PW_LONG_CYC;
        check("width", 24'(n), 24'(w));
        check("blank", {23'h0, disp.blank}, 24'h0);
        check("count", v, exp);
    endtask
    task automatic stop_osc;
        @(posedge clk);
        run <= 1'b0;
        repeat (3200) @(negedge clk);
        check("idle blank", {23'h0, disp.blank}, 24'h1);
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check("reset blank", {23'h0, disp.blank}, 24'h1);
        measure(2'h2, 16'h04E2, 5000 / 1250);
        measure(2'h3, 16'h007D, 5000 / 125 / `MFC_PRESCALE);
        measure(2'h0, 16'h07D0, 5000 * `MFC_DIV_LOW / 2000);
        stop_osc();
        measure(2'h1, 16'h07D0, 5000 * `MFC_DIV_MID / 2000);
        finish_test();
    end
endmodule
`default_nettype wire
